// File: tep_pkg.sv
// Shared constants and types for the timer external pin block
package tep_pkg;
   // Register byte offsets
   localparam logic [4:0] OFF_CTRL = 5'h00;
   localparam logic [4:0] OFF_T0 = 5'h04;
   localparam logic [4:0] OFF_T1 = 5'h08;
   localparam logic [4:0] OFF_T2 = 5'h0C;
   localparam logic [4:0] OFF_RCAP = 5'h10;
   localparam logic [4:0] OFF_STAT = 5'h14;
   // Status field positions
   localparam int STAT_FLAG_LSB = 0;
   localparam int STAT_DIR_BIT = 4;
   localparam int STAT_PIN_LSB = 8;
   // Status flag indices
   localparam int FLG_T0_OVF = 0;
   localparam int FLG_T1_OVF = 1;
   localparam int FLG_T2_OVF = 2;
   localparam int FLG_T2_EXT = 3;
   // Reset values
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [3:0] FLAG_RST = 4'h0;
   // Internal count tick divider, in core clock cycles
   localparam int TICK_DIV = 12;
   // Pin sampler lane indices
   localparam int PIN_T0 = 0;
   localparam int PIN_T1 = 1;
   localparam int PIN_T2 = 2;
   localparam int PIN_TIMER2_EXT_CONTROL_PIN = 3;
   localparam int PIN_N = 4;

   typedef enum logic [2:0] {
      T2_STOP,
      T2_CAPTURE,
      T2_RELOAD,
      T2_UPDOWN,
      T2_CLKOUT
   } tep_t2_mode_e;

   typedef struct packed {
      tep_t2_mode_e t2_mode;
      logic t2_run;
      logic t1_run;
      logic t0_run;
      logic t1_cnt;
      logic t0_cnt;
   } tep_ctrl_s;
endpackage

// File: tep_pin_sync.sv
// Two-flop pin synchroniser with registered falling edge detect
`timescale 1ns/1ps
module tep_pin_sync #(
   parameter int W = 4
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [W-1:0] pin_raw,
   output logic [W-1:0] pin_lvl,
   output logic [W-1:0] pin_fall
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] lvl_ff;
   logic [W-1:0] prev_ff;

   generate
      if (W < 1) begin : g_chk
         $error("tep_pin_sync: W must be at least 1");
      end
   endgenerate

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_ff <= '1;
         lvl_ff <= '1;
         prev_ff <= '1;
      end else begin
         meta_ff <= pin_raw;
         lvl_ff <= meta_ff;
         prev_ff <= lvl_ff;
      end
   end

   assign pin_lvl = lvl_ff;
   // High sample followed by low sample
   assign pin_fall = prev_ff & ~lvl_ff;
endmodule

// File: tep_tick_div.sv
// Divider producing a one-cycle count tick enable
`timescale 1ns/1ps
module tep_tick_div #(
   parameter int DIV = 12
) (
   input wire logic core_clk,
   input wire logic rst_n,
   output logic tick
);
   localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
   localparam logic [CW-1:0] LAST = CW'(DIV - 1);
   logic [CW-1:0] cnt_ff;
   logic tick_ff;

   generate
      if (DIV < 2) begin : g_chk
         $error("tep_tick_div: DIV must be at least 2");
      end
   endgenerate

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff <= '0;
         tick_ff <= 1'b0;
      end else begin
         tick_ff <= (cnt_ff == LAST);
         cnt_ff <= (cnt_ff == LAST) ? '0 : cnt_ff + 1'b1;
      end
   end

   assign tick = tick_ff;
endmodule

// File: tep_timer_pins.sv
// Timer external pin logic with Avalon-MM register slave
// Contract
// - Timers 0/1 in counter mode add one per falling edge on their count input.
// - Timer 2 capture mode: clock pin is an input clocking timer 2.
// - Timer 2 clock-out mode: clock pin driven with timer 2 generated clock.
// - Capture mode: control pin falling edge captures timer 2 count.
// - Auto-reload mode: control pin falling edge reloads timer 2 count.
// - Up-down mode: control pin high counts up, low counts down.
//
// Implementation choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
module tep_timer_pins #(
   parameter int CNT_W = 16,
   parameter int TICK_DIV = tep_pkg::TICK_DIV
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [1:0] timer01_count_input,
   input wire logic timer2_clock_pin_in,
   input wire logic timer2_ext_control_pin,
   output logic timer2_clock_pin_out,
   output logic timer2_clock_pin_oe
);
   generate
      if (CNT_W < 8 || CNT_W > 32) begin : g_chk
         $error("tep_timer_pins: CNT_W must be 8 to 32");
      end
   endgenerate

   localparam logic [CNT_W-1:0] CNT_TOP = '1;

   // Byte-enable merge of write data into an old value
   function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction

   tep_pkg::tep_ctrl_s ctrl_ff;
   logic [CNT_W-1:0] t01_cnt_ff [2];
   logic [CNT_W-1:0] t2_cnt_ff;
   logic [CNT_W-1:0] rcap_ff;
   logic [3:0] flag_ff;
   logic [3:0] flag_set;
   logic [3:0] flag_clr;
   logic t2_clkout_ff;
   logic pin_out_ff;
   logic pin_oe_ff;
   logic wait_ff;
   logic [31:0] rdata_ff;
   logic [31:0] nxt_rdata;
   logic wr_acc;
   logic tick;
   logic [tep_pkg::PIN_N-1:0] pin_lvl;
   logic [tep_pkg::PIN_N-1:0] pin_fall;
   logic [1:0] t01_run;
   logic [1:0] t01_cnt_mode;
   logic [1:0] t01_inc;
   logic t2_adv;
   logic t2_down;
   logic t2_top;
   logic t2_floor;
   logic t2_wr;
   logic rcap_wr;
   logic timer2_ext_control_pin_fall;

   tep_pin_sync #(
      .W(tep_pkg::PIN_N)
   ) u_sync (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .pin_raw({timer2_ext_control_pin, timer2_clock_pin_in, timer01_count_input}),
      .pin_lvl(pin_lvl),
      .pin_fall(pin_fall)
   );

   tep_tick_div #(
      .DIV(TICK_DIV)
   ) u_div (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .tick(tick)
   );

   // Bus slave: one wait cycle, then answer for one cycle
   assign wr_acc = avs_write && !wait_ff;

   always_comb begin
      nxt_rdata = 32'h0000_0000;
      if (avs_address == tep_pkg::OFF_CTRL) begin
         nxt_rdata = 32'(ctrl_ff);
      end else if (avs_address == tep_pkg::OFF_T0) begin
         nxt_rdata = 32'(t01_cnt_ff[0]);
      end else if (avs_address == tep_pkg::OFF_T1) begin
         nxt_rdata = 32'(t01_cnt_ff[1]);
      end else if (avs_address == tep_pkg::OFF_T2) begin
         nxt_rdata = 32'(t2_cnt_ff);
      end else if (avs_address == tep_pkg::OFF_RCAP) begin
         nxt_rdata = 32'(rcap_ff);
      end else if (avs_address == tep_pkg::OFF_STAT) begin
         nxt_rdata[tep_pkg::STAT_FLAG_LSB +: 4] = flag_ff;
         nxt_rdata[tep_pkg::STAT_DIR_BIT] = !t2_down;
         nxt_rdata[tep_pkg::STAT_PIN_LSB +: tep_pkg::PIN_N] = pin_lvl;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wait_ff <= 1'b1;
         rdata_ff <= 32'h0000_0000;
      end else if (wait_ff && (avs_read || avs_write)) begin
         wait_ff <= 1'b0;
         rdata_ff <= avs_read ? nxt_rdata : 32'h0000_0000;
      end else begin
         wait_ff <= 1'b1;
      end
   end

   assign avs_waitrequest = wait_ff;
   assign avs_readdata = rdata_ff;

   // Control register
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_ff <= tep_pkg::tep_ctrl_s'(tep_pkg::CTRL_RST);
      end else if (wr_acc && avs_address == tep_pkg::OFF_CTRL && avs_byteenable[0]) begin
         ctrl_ff <= tep_pkg::tep_ctrl_s'(avs_writedata[7:0]);
      end
   end

   // Timers 0 and 1
   assign t01_run = {ctrl_ff.t1_run, ctrl_ff.t0_run};
   assign t01_cnt_mode = {ctrl_ff.t1_cnt, ctrl_ff.t0_cnt};

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_t01
         localparam logic [4:0] OFF = (gi == 0) ? tep_pkg::OFF_T0 : tep_pkg::OFF_T1;
         assign t01_inc[gi] = t01_run[gi] && (t01_cnt_mode[gi] ? pin_fall[gi] : tick);
         assign flag_set[gi] = t01_inc[gi] && (t01_cnt_ff[gi] == CNT_TOP);
         always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
               t01_cnt_ff[gi] <= '0;
            end else if (wr_acc && avs_address == OFF) begin
               t01_cnt_ff[gi] <= CNT_W'(be_merge(32'(t01_cnt_ff[gi]), avs_writedata,
                                                 avs_byteenable));
            end else if (t01_inc[gi]) begin
               t01_cnt_ff[gi] <= t01_cnt_ff[gi] + 1'b1;
            end
         end
      end
   endgenerate

   // Timer 2
   assign timer2_ext_control_pin_fall = pin_fall[tep_pkg::PIN_TIMER2_EXT_CONTROL_PIN] && ctrl_ff.t2_run;
   assign t2_wr = wr_acc && avs_address == tep_pkg::OFF_T2;
   assign rcap_wr = wr_acc && avs_address == tep_pkg::OFF_RCAP;
   assign t2_down = (ctrl_ff.t2_mode == tep_pkg::T2_UPDOWN) && !pin_lvl[tep_pkg::PIN_TIMER2_EXT_CONTROL_PIN];
   assign t2_top = (t2_cnt_ff == CNT_TOP);
   assign t2_floor = (t2_cnt_ff == rcap_ff);

   always_comb begin
      t2_adv = 1'b0;
      case (ctrl_ff.t2_mode)
         tep_pkg::T2_CAPTURE: t2_adv = pin_fall[tep_pkg::PIN_T2];
         tep_pkg::T2_RELOAD: t2_adv = tick;
         tep_pkg::T2_UPDOWN: t2_adv = tick;
         tep_pkg::T2_CLKOUT: t2_adv = tick;
         default: t2_adv = 1'b0;
      endcase
      t2_adv = t2_adv && ctrl_ff.t2_run;
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         t2_cnt_ff <= '0;
      end else if (t2_wr) begin
         t2_cnt_ff <= CNT_W'(be_merge(32'(t2_cnt_ff), avs_writedata, avs_byteenable));
      end else if (ctrl_ff.t2_mode == tep_pkg::T2_RELOAD && timer2_ext_control_pin_fall) begin
         t2_cnt_ff <= rcap_ff;
      end else if (t2_adv) begin
         if (t2_down) begin
            t2_cnt_ff <= t2_floor ? CNT_TOP : t2_cnt_ff - 1'b1;
         end else if (t2_top) begin
            t2_cnt_ff <= (ctrl_ff.t2_mode == tep_pkg::T2_CAPTURE) ? '0 : rcap_ff;
         end else begin
            t2_cnt_ff <= t2_cnt_ff + 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rcap_ff <= '0;
      end else if (rcap_wr) begin
         rcap_ff <= CNT_W'(be_merge(32'(rcap_ff), avs_writedata, avs_byteenable));
      end else if (ctrl_ff.t2_mode == tep_pkg::T2_CAPTURE && timer2_ext_control_pin_fall) begin
         rcap_ff <= t2_cnt_ff;
      end
   end

   assign flag_set[tep_pkg::FLG_T2_OVF] = t2_adv && (t2_down ? t2_floor : t2_top);
   assign flag_set[tep_pkg::FLG_T2_EXT] = timer2_ext_control_pin_fall &&
      (ctrl_ff.t2_mode == tep_pkg::T2_CAPTURE || ctrl_ff.t2_mode == tep_pkg::T2_RELOAD);

   // Sticky status flags, write one to clear, set wins
   assign flag_clr = (wr_acc && avs_address == tep_pkg::OFF_STAT && avs_byteenable[0]) ?
                     avs_writedata[tep_pkg::STAT_FLAG_LSB +: 4] : 4'h0;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         flag_ff <= tep_pkg::FLAG_RST;
      end else begin
         flag_ff <= (flag_ff & ~flag_clr) | flag_set;
      end
   end

   // Clock-out generation and pin drive
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         t2_clkout_ff <= 1'b0;
      end else if (ctrl_ff.t2_mode != tep_pkg::T2_CLKOUT) begin
         t2_clkout_ff <= 1'b0;
      end else if (t2_adv && t2_top) begin
         t2_clkout_ff <= !t2_clkout_ff;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_oe_ff <= 1'b0;
         pin_out_ff <= 1'b0;
      end else begin
         pin_oe_ff <= (ctrl_ff.t2_mode == tep_pkg::T2_CLKOUT);
         pin_out_ff <= t2_clkout_ff;
      end
   end

   assign timer2_clock_pin_oe = pin_oe_ff;
   assign timer2_clock_pin_out = pin_out_ff;

   // Checks
   chk_t0_count_fall: assert property (@(posedge core_clk) disable iff (!rst_n)
      (ctrl_ff.t0_run && ctrl_ff.t0_cnt && pin_fall[0] && !(wr_acc && avs_address ==
       tep_pkg::OFF_T0)) |=> t01_cnt_ff[0] == CNT_W'($past(t01_cnt_ff[0]) + 1'b1))
      else $error("timer 0 missed a count input falling edge");
   chk_t1_hold_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
      (ctrl_ff.t1_cnt && !pin_fall[1] && !(wr_acc && avs_address == tep_pkg::OFF_T1))
      |=> $stable(t01_cnt_ff[1]))
      else $error("timer 1 counted without a falling edge");
   chk_edge_from_pin: assert property (@(posedge core_clk) disable iff (!rst_n)
      pin_fall[0] |-> ($past(timer01_count_input[0], 3) && !$past(timer01_count_input[0], 2)))
      else $error("falling edge not preceded by high then low sample");
   chk_t2_capture_input: assert property (@(posedge core_clk) disable iff (!rst_n)
      (ctrl_ff.t2_mode == tep_pkg::T2_CAPTURE && !pin_fall[tep_pkg::PIN_T2] && !t2_wr)
      |=> (!timer2_clock_pin_oe && $stable(t2_cnt_ff)))
      else $error("timer 2 capture mode pin driven or count moved without clock");
   chk_t2_clkout_drive: assert property (@(posedge core_clk) disable iff (!rst_n)
      (ctrl_ff.t2_mode == tep_pkg::T2_CLKOUT) ##1 (ctrl_ff.t2_mode == tep_pkg::T2_CLKOUT)
      |=> (timer2_clock_pin_oe && timer2_clock_pin_out == $past(t2_clkout_ff)))
      else $error("clock-out mode pin not carrying the timer 2 clock");
   chk_t2_capture_value: assert property (@(posedge core_clk) disable iff (!rst_n)
      (ctrl_ff.t2_mode == tep_pkg::T2_CAPTURE && timer2_ext_control_pin_fall && !rcap_wr)
      |=> rcap_ff == $past(t2_cnt_ff))
      else $error("capture did not take the timer 2 count");
   chk_t2_reload_ext: assert property (@(posedge core_clk) disable iff (!rst_n)
      (ctrl_ff.t2_mode == tep_pkg::T2_RELOAD && timer2_ext_control_pin_fall && !t2_wr)
      |=> t2_cnt_ff == $past(rcap_ff))
      else $error("control pin edge did not reload timer 2");
   chk_t2_updown_dir: assert property (@(posedge core_clk) disable iff (!rst_n)
      (ctrl_ff.t2_mode == tep_pkg::T2_UPDOWN && t2_adv && !t2_wr && !t2_top && !t2_floor)
      |=> t2_cnt_ff == ($past(pin_lvl[tep_pkg::PIN_TIMER2_EXT_CONTROL_PIN]) ? CNT_W'($past(t2_cnt_ff) + 1'b1)
                                                        : CNT_W'($past(t2_cnt_ff) - 1'b1)))
      else $error("up-down direction does not follow control pin");
   chk_flag_set_wins: assert property (@(posedge core_clk) disable iff (!rst_n)
      flag_set[tep_pkg::FLG_T2_EXT] |=> flag_ff[tep_pkg::FLG_T2_EXT])
      else $error("timer 2 external edge flag lost");

   cov_t0_pin_count: cover property (@(posedge core_clk) disable iff (!rst_n)
      t01_inc[0] && ctrl_ff.t0_cnt);
   cov_t2_capture: cover property (@(posedge core_clk) disable iff (!rst_n)
      ctrl_ff.t2_mode == tep_pkg::T2_CAPTURE && timer2_ext_control_pin_fall);
   cov_t2_clkout_toggle: cover property (@(posedge core_clk) disable iff (!rst_n)
      $rose(timer2_clock_pin_out));
   cov_t2_reload: cover property (@(posedge core_clk) disable iff (!rst_n)
      ctrl_ff.t2_mode == tep_pkg::T2_RELOAD && timer2_ext_control_pin_fall);
endmodule

// File: tep_pin_src.sv
// External pulse source model driving the timer pins
`timescale 1ns/1ps
module tep_pin_src (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic go,
   input wire logic [1:0] lane,
   input wire logic [7:0] npulse,
   input wire logic [3:0] base,
   output logic busy,
   output logic [3:0] pins
);
   logic [7:0] left_ff;
   logic [2:0] ph_ff;
   logic [1:0] lane_ff;
   // Each pulse inverts the lane's base level for three clocks, then back at base for three
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         left_ff <= 8'h00;
         ph_ff <= 3'h0;
         lane_ff <= 2'h0;
      end else if (go) begin
         left_ff <= npulse;
         lane_ff <= lane;
         ph_ff <= 3'h0;
      end else if (left_ff != 8'h00) begin
         ph_ff <= (ph_ff == 3'h5) ? 3'h0 : ph_ff + 3'h1;
         if (ph_ff == 3'h5) begin
            left_ff <= left_ff - 8'h01;
         end
      end
   end
   assign busy = (left_ff != 8'h00);
   // Base level is held steady between pulses, direction level included
   assign pins = base ^ ((busy && ph_ff < 3'h3) ? (4'h1 << lane_ff) : 4'h0);
endmodule

// File: tb_top.sv
// Self-checking testbench for the timer external pin block
`timescale 1ns/1ps
module tb_top;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [4:0] avs_address = 5'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'hF;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic pin_out;
   logic pin_oe;
   logic clk_wire;
   logic src_go = 1'b0;
   logic [1:0] src_lane = 2'h0;
   logic [7:0] src_n = 8'h00;
   logic [3:0] src_base = 4'hF;
   logic src_busy;
   logic [3:0] pins;
   logic [31:0] rdata;
   logic [31:0] prev;
   int n_mismatch = 0;
   int check_count = 0;
   int n;
   assign clk_wire = pin_oe ? pin_out : pins[2];
   tep_pin_src tep_pin_src_inst (.core_clk(core_clk), .rst_n(rst_n), .go(src_go),
      .lane(src_lane), .npulse(src_n), .base(src_base), .busy(src_busy), .pins(pins));
   tep_timer_pins #(.CNT_W(16), .TICK_DIV(2)) tep_timer_pins_inst (.core_clk(core_clk),
      .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .timer01_count_input(pins[1:0]), .timer2_clock_pin_in(clk_wire),
      .timer2_ext_control_pin(pins[3]), .timer2_clock_pin_out(pin_out),
      .timer2_clock_pin_oe(pin_oe));
   initial begin
      forever #5 core_clk = ~core_clk;
   end
   task automatic complete_run();
      $display("mismatches %0d checks %0d", n_mismatch, check_count);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic guard(input int cnt, input int lim);
      if (cnt >= lim) begin
         n_mismatch++;
         $display("MISMATCH t=%0t wait limit reached", $time);
         complete_run();
      end
   endtask
   task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t word got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cmp_bit(input logic got, input logic exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t bit got %b exp %b", $time, got, exp);
      end
   endtask
   // Holds the request until waitrequest is sampled low, then releases
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                      input logic [3:0] be);
      int k;
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= d;
      avs_byteenable <= be;
      k = 0;
      do begin
         @(posedge core_clk);
         k++;
      end while (avs_waitrequest !== 1'b0 && k < 40);
      rdata = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (avs_waitrequest !== 1'b0) begin
         guard(40, 40);
      end
      @(posedge core_clk);
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 4'hF);
   endtask
   task automatic rd(input logic [4:0] a);
      bus(1'b0, a, 32'h0, 4'hF);
   endtask
   task automatic pulse(input logic [1:0] l, input logic [7:0] k);
      int c;
      src_lane <= l;
      src_n <= k;
      src_go <= 1'b1;
      @(posedge core_clk);
      src_go <= 1'b0;
      c = 0;
      do begin
         @(posedge core_clk);
         c++;
      end while (src_busy !== 1'b0 && c < 3000);
      guard(c, 3000);
      repeat (6) @(posedge core_clk);
   endtask
   initial begin
      repeat (3) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      rd(tep_pkg::OFF_CTRL);
      cmp_word(rdata, 32'h0);
      rd(tep_pkg::OFF_T0);
      cmp_word(rdata, 32'h0);
      rd(5'h18);
      cmp_word(rdata, 32'h0);
      rd(tep_pkg::OFF_STAT);
      cmp_word(rdata & 32'hF0F, 32'hF00);
      bus(1'b1, tep_pkg::OFF_CTRL, 32'h0F, 4'hE);
      rd(tep_pkg::OFF_CTRL);
      cmp_word(rdata, 32'h0);
      // Counter mode on both lanes, unequal counts
      wr(tep_pkg::OFF_CTRL, 32'h0F);
      pulse(2'h0, 8'h05);
      pulse(2'h1, 8'h03);
      rd(tep_pkg::OFF_T0);
      cmp_word(rdata, 32'h5);
      rd(tep_pkg::OFF_T1);
      cmp_word(rdata, 32'h3);
      wr(tep_pkg::OFF_CTRL, 32'h03);
      pulse(2'h0, 8'h02);
      rd(tep_pkg::OFF_T0);
      cmp_word(rdata, 32'h5);
      // Capture mode: clock pin is the count clock, control fall captures
      wr(tep_pkg::OFF_CTRL, 32'h30);
      wr(tep_pkg::OFF_T2, 32'h0);
      wr(tep_pkg::OFF_STAT, 32'hF);
      cmp_bit(pin_oe, 1'b0);
      pulse(2'h2, 8'h04);
      rd(tep_pkg::OFF_T2);
      cmp_word(rdata, 32'h4);
      pulse(2'h3, 8'h01);
      rd(tep_pkg::OFF_RCAP);
      cmp_word(rdata, 32'h4);
      rd(tep_pkg::OFF_STAT);
      cmp_bit(rdata[3], 1'b1);
      // Auto-reload mode: control fall loads the reload value
      wr(tep_pkg::OFF_CTRL, 32'h50);
      wr(tep_pkg::OFF_RCAP, 32'h1234);
      wr(tep_pkg::OFF_T2, 32'h0);
      pulse(2'h3, 8'h01);
      rd(tep_pkg::OFF_T2);
      cmp_bit(rdata >= 32'h1234 && rdata <= 32'h1250, 1'b1);
      // Up-down mode: low control level counts down
      src_base <= 4'h7;
      wr(tep_pkg::OFF_RCAP, 32'h0);
      wr(tep_pkg::OFF_CTRL, 32'h70);
      wr(tep_pkg::OFF_T2, 32'h8000);
      // Let at least one tick pass whatever the divider phase
      repeat (4) @(posedge core_clk);
      rd(tep_pkg::OFF_T2);
      cmp_bit(rdata >= 32'h7FE0 && rdata < 32'h8000, 1'b1);
      rd(tep_pkg::OFF_STAT);
      cmp_bit(rdata[4], 1'b0);
      src_base <= 4'hF;
      repeat (6) @(posedge core_clk);
      rd(tep_pkg::OFF_T2);
      prev = rdata;
      repeat (20) @(posedge core_clk);
      rd(tep_pkg::OFF_T2);
      cmp_bit(rdata > prev, 1'b1);
      rd(tep_pkg::OFF_STAT);
      cmp_bit(rdata[4], 1'b1);
      // Clock-out mode: device drives the pin and toggles it
      wr(tep_pkg::OFF_RCAP, 32'hFFF0);
      wr(tep_pkg::OFF_T2, 32'hFFF0);
      wr(tep_pkg::OFF_CTRL, 32'h90);
      repeat (3) @(posedge core_clk);
      cmp_bit(pin_oe, 1'b1);
      prev[0] = pin_out;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (pin_out === prev[0] && n < 200);
      guard(n, 200);
      cmp_bit(pin_out, ~prev[0]);
      cmp_bit(clk_wire, pin_out);
      wr(tep_pkg::OFF_CTRL, 32'h30);
      repeat (3) @(posedge core_clk);
      cmp_bit(pin_oe, 1'b0);
      complete_run();
   end
endmodule
